// *** shared/smsu_pkg.sv ***
package smsu_pkg;
  localparam int SMSU_VEC_W = 128;
  localparam int SMSU_DVEC_W = 64;
  localparam int SMSU_LANE_W = 2;
  localparam int SMSU_STAT_W = 32;
  localparam int SMSU_SAT_BIT = 27;
  localparam logic [SMSU_STAT_W-1:0] SMSU_STAT_RST = 32'h0000_0000;
  localparam logic [1:0] SMSU_MAX_LANE_H = 2'h3;
  localparam logic [1:0] SMSU_MAX_LANE_W = 2'h1;
  localparam int SMSU_LAT = 1;

  typedef enum logic [2:0] {
    SMSU_OP_MULL,
    SMSU_OP_QDMULL,
    SMSU_OP_QDMULH,
    SMSU_OP_QRDMULH
  } smsu_op_t;

  typedef enum logic [1:0] {
    SMSU_ST_IDLE,
    SMSU_ST_ISSUE,
    SMSU_ST_WAIT
  } smsu_state_t;
endpackage

// *** shared/smsu_if.sv ***
`timescale 1ns/100ps
interface smsu_if;
  import smsu_pkg::*;
  logic req;
  smsu_op_t op;
  logic esz32;
  logic is_signed;
  logic quad;
  logic use_lane;
  logic [1:0] lane;
  logic [SMSU_VEC_W-1:0] vec_a;
  logic [SMSU_DVEC_W-1:0] vec_b;
  logic [31:0] scalar;
  logic stat_wr;
  logic [SMSU_STAT_W-1:0] stat_wdata;
  logic done;
  logic [SMSU_VEC_W-1:0] result;
  logic sat;
  logic [SMSU_STAT_W-1:0] stat;

  modport unit (
    input req, op, esz32, is_signed, quad, use_lane, lane, vec_a, vec_b, scalar,
    input stat_wr, stat_wdata,
    output done, result, sat, stat
  );
  modport issue (
    output req, op, esz32, is_signed, quad, use_lane, lane, vec_a, vec_b, scalar,
    output stat_wr, stat_wdata,
    input done, result, sat, stat
  );
endinterface

// *** src/smsu_unit.sv ***
// Contract
// - every first-source lane times one scalar
// - widening scalar is direct or lane-indexed second-source element
// - widening results are double element width
// - widening: s/u 16/32, index 0-3 / 0-1
// - direct-scalar widening saturating multiply doubles product
// - overflow clamps result, sets sticky bit 27
// - saturating lane forms take scalar by index
// - saturating widening is signed 16/32 only
// - high-half returns upper half of doubled product
// - rounding variant rounds, then saturates likewise
// - direct high-half on 64 and 128-bit vectors
// - 128-bit lane forms index a 64-bit vector
// - rounding offered direct and lane, both widths
`timescale 1ns/100ps
module smsu_unit
  import smsu_pkg::*;
(
  input wire logic i_mclk,     // processor clock
  input wire logic i_rst_n,    // async reset, active low
  smsu_if.unit bus             // issue-side link
);
  // one lane's arithmetic; w32 selects 32-bit elements
  function automatic logic [64:0] lane_op(input logic [31:0] a, input logic [31:0] b,
                                          input smsu_op_t op, input logic w32,
                                          input logic sgn);
    logic signed [64:0] p;
    logic signed [65:0] d;
    logic [63:0] r;
    logic ov;
    p = '0;
    d = '0;
    r = '0;
    ov = 1'b0;
    if (w32) begin
      if (sgn) p = 65'(signed'(a)) * 65'(signed'(b));
      else p = signed'({33'h0, a}) * signed'({33'h0, b});
    end else begin
      if (sgn) p = 65'(signed'(a[15:0])) * 65'(signed'(b[15:0]));
      else p = signed'({49'h0, a[15:0]}) * signed'({49'h0, b[15:0]});
    end
    d = 66'(p) <<< 1;
    if (op == SMSU_OP_QRDMULH) d = d + (w32 ? 66'sh0_8000_0000 : 66'sh8000);
    case (op)
      SMSU_OP_MULL: r = p[63:0];
      SMSU_OP_QDMULL: begin
        // only min*min reaches past the wide range; clamp to max positive
        if (w32) begin
          ov = (d > 66'sh0_7fff_ffff_ffff_ffff);
          r = ov ? 64'h7fff_ffff_ffff_ffff : d[63:0];
        end else begin
          ov = (d > 66'sh7fff_ffff);
          r = ov ? 64'h0000_0000_7fff_ffff : {32'h0, d[31:0]};
        end
      end
      default: begin
        if (w32) begin
          // part-selects are unsigned; compare signed so negative halves never clamp
          ov = (signed'(d[65:32]) > 34'sh0_7fff_ffff);
          r = ov ? 64'h0000_0000_7fff_ffff : {32'h0, d[63:32]};
        end else begin
          ov = (signed'(d[65:16]) > 50'sh7fff);
          r = ov ? 64'h0000_0000_0000_7fff : {48'h0, d[31:16]};
        end
      end
    endcase
    return {ov, r};
  endfunction

  logic [SMSU_VEC_W-1:0] result_reg, result_next;
  logic done_reg, done_next;
  logic sat_reg, sat_next;
  logic [SMSU_STAT_W-1:0] stat_reg, stat_next;
  logic [31:0] scal;
  logic [1:0] ln;
  logic any_ov;

  always_comb begin
    logic [64:0] t;
    logic [31:0] ea;
    t = '0;
    ea = '0;
    result_next = '0;
    any_ov = 1'b0;
    // the issue side keeps the index in range; it is masked here anyway
    ln = bus.esz32 ? (bus.lane & SMSU_MAX_LANE_W) : (bus.lane & SMSU_MAX_LANE_H);
    if (bus.use_lane) begin
      scal = bus.esz32 ? bus.vec_b[ln[0]*32 +: 32] : {16'h0, bus.vec_b[ln*16 +: 16]};
    end else begin
      scal = bus.scalar;
    end
    if (bus.op == SMSU_OP_MULL || bus.op == SMSU_OP_QDMULL) begin
      for (int i = 0; i < 4; i++) begin
        if (!bus.esz32) begin
          t = lane_op({16'h0, bus.vec_a[i*16 +: 16]}, scal, bus.op, 1'b0, bus.is_signed);
          result_next[i*32 +: 32] = t[31:0];
          any_ov = any_ov | t[64];
        end else if (i < 2) begin
          t = lane_op(bus.vec_a[i*32 +: 32], scal, bus.op, 1'b1, bus.is_signed);
          result_next[i*64 +: 64] = t[63:0];
          any_ov = any_ov | t[64];
        end
      end
    end else begin
      // high-half: 4 or 8 halfword lanes, 2 or 4 word lanes
      for (int i = 0; i < 8; i++) begin
        if (!bus.esz32 && (bus.quad || i < 4)) begin
          t = lane_op({16'h0, bus.vec_a[i*16 +: 16]}, scal, bus.op, 1'b0, 1'b1);
          result_next[i*16 +: 16] = t[15:0];
          any_ov = any_ov | t[64];
        end else if (bus.esz32 && (bus.quad ? i < 4 : i < 2)) begin
          t = lane_op(bus.vec_a[i*32 +: 32], scal, bus.op, 1'b1, 1'b1);
          result_next[i*32 +: 32] = t[31:0];
          any_ov = any_ov | t[64];
        end
      end
    end
    if (!bus.req) result_next = result_reg;
    done_next = bus.req;
    sat_next = bus.req & any_ov;
    stat_next = bus.stat_wr ? bus.stat_wdata : stat_reg;
    // a saturating result in the same cycle as a clear still sets the flag
    if (bus.req && any_ov) stat_next[SMSU_SAT_BIT] = 1'b1;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_reg <= '0;
      done_reg <= 1'b0;
      sat_reg <= 1'b0;
      stat_reg <= SMSU_STAT_RST;
    end else begin
      result_reg <= result_next;
      done_reg <= done_next;
      sat_reg <= sat_next;
      stat_reg <= stat_next;
    end
  end

  assign bus.result = result_reg;
  assign bus.done = done_reg;
  assign bus.sat = sat_reg;
  assign bus.stat = stat_reg;
endmodule

// *** src/smsu_issue.sv ***
`timescale 1ns/100ps
module smsu_issue
  import smsu_pkg::*;
(
  input wire logic i_mclk,                      // processor clock
  input wire logic i_rst_n,                     // async reset, active low
  input wire logic i_go,                        // request one operation, pulse
  input wire smsu_op_t i_op,                    // operation
  input wire logic i_esz32,                     // 1: 32-bit elements
  input wire logic i_signed,                    // signed elements (widening only)
  input wire logic i_quad,                      // 128-bit high-half form
  input wire logic i_use_lane,                  // scalar from lane of vec_b
  input wire logic [1:0] i_lane,                // lane index
  input wire logic [SMSU_VEC_W-1:0] i_vec_a,    // first source
  input wire logic [SMSU_DVEC_W-1:0] i_vec_b,   // 64-bit scalar vector
  input wire logic [31:0] i_scalar,             // direct scalar
  input wire logic i_stat_wr,                   // software status write, pulse
  input wire logic [SMSU_STAT_W-1:0] i_stat_wdata, // status write value
  output logic o_busy,                          // operation in flight
  output logic o_rejected,                      // last request illegal, pulse
  output logic o_valid,                         // result valid, pulse
  output logic [SMSU_VEC_W-1:0] o_result,       // captured result
  output logic o_saturated,                     // last result saturated
  output logic [SMSU_STAT_W-1:0] o_status,      // status register copy
  smsu_if.issue bus                             // unit-side link
);
  smsu_state_t state_reg, state_next;
  logic req_reg, req_next;
  logic rej_reg, rej_next;
  logic valid_reg, valid_next;
  logic [SMSU_VEC_W-1:0] res_reg, res_next;
  logic sat_reg, sat_next;
  logic [SMSU_STAT_W-1:0] stat_reg;
  logic legal;
  logic [SMSU_VEC_W-1:0] a_reg, a_next;
  logic [SMSU_DVEC_W-1:0] b_reg, b_next;
  logic [31:0] s_reg, s_next;
  logic [7:0] cfg_reg, cfg_next;
  logic [1:0] b_lane_reg;
  logic busy_reg, busy_next;

  always_comb begin
    // lane range, signed-only forms, 128-bit only for high-half
    legal = (i_lane <= (i_esz32 ? SMSU_MAX_LANE_W : SMSU_MAX_LANE_H) || !i_use_lane)
          && (i_signed || i_op == SMSU_OP_MULL)
          && (!i_quad || i_op == SMSU_OP_QDMULH || i_op == SMSU_OP_QRDMULH);
    state_next = state_reg;
    req_next = 1'b0;
    rej_next = 1'b0;
    valid_next = 1'b0;
    res_next = res_reg;
    sat_next = sat_reg;
    a_next = a_reg;
    b_next = b_reg;
    s_next = s_reg;
    cfg_next = cfg_reg;
    case (state_reg)
      SMSU_ST_IDLE: begin
        if (i_go && legal) begin
          state_next = SMSU_ST_ISSUE;
          req_next = 1'b1;
          a_next = i_vec_a;
          b_next = i_vec_b;
          s_next = i_scalar;
          cfg_next = {i_op, i_esz32, i_signed, i_quad, i_use_lane, 1'b0};
        end else if (i_go) begin
          rej_next = 1'b1;
        end
      end
      SMSU_ST_ISSUE: state_next = SMSU_ST_WAIT;
      SMSU_ST_WAIT: begin
        if (bus.done) begin
          state_next = SMSU_ST_IDLE;
          valid_next = 1'b1;
          res_next = bus.result;
          sat_next = bus.sat;
        end
      end
      default: state_next = SMSU_ST_IDLE;
    endcase
    busy_next = (state_next != SMSU_ST_IDLE);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= SMSU_ST_IDLE;
      busy_reg <= 1'b0;
      req_reg <= 1'b0;
      rej_reg <= 1'b0;
      valid_reg <= 1'b0;
      res_reg <= '0;
      sat_reg <= 1'b0;
      stat_reg <= SMSU_STAT_RST;
      a_reg <= '0;
      b_reg <= '0;
      s_reg <= '0;
      cfg_reg <= '0;
    end else begin
      state_reg <= state_next;
      busy_reg <= busy_next;
      req_reg <= req_next;
      rej_reg <= rej_next;
      valid_reg <= valid_next;
      res_reg <= res_next;
      sat_reg <= sat_next;
      stat_reg <= bus.stat;
      a_reg <= a_next;
      b_reg <= b_next;
      s_reg <= s_next;
      cfg_reg <= cfg_next;
    end
  end

  assign bus.req = req_reg;
  assign bus.op = smsu_op_t'(cfg_reg[7:5]);
  assign bus.esz32 = cfg_reg[4];
  assign bus.is_signed = cfg_reg[3];
  assign bus.quad = cfg_reg[2];
  assign bus.use_lane = cfg_reg[1];
  assign bus.lane = b_lane_reg;
  assign bus.vec_a = a_reg;
  assign bus.vec_b = b_reg;
  assign bus.scalar = s_reg;
  assign bus.stat_wr = i_stat_wr;
  assign bus.stat_wdata = i_stat_wdata;
  assign o_busy = busy_reg;
  assign o_rejected = rej_reg;
  assign o_valid = valid_reg;
  assign o_result = res_reg;
  assign o_saturated = sat_reg;
  assign o_status = stat_reg;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) b_lane_reg <= 2'h0;
    else if (state_reg == SMSU_ST_IDLE && i_go) b_lane_reg <= i_lane;
  end
endmodule

// *** tb/smsu_properties.sv ***
`timescale 1ns/100ps
module smsu_properties
  import smsu_pkg::*;
(
  input wire logic i_mclk, // clock
  input wire logic i_rst_n, // reset
  input wire logic req, // request
  input wire smsu_op_t op, // operation
  input wire logic esz32, // 32-bit elements
  input wire logic quad, // 128-bit form
  input wire logic use_lane, // lane scalar
  input wire logic [SMSU_VEC_W-1:0] vec_a, // source
  input wire logic [31:0] scalar, // scalar
  input wire logic stat_wr, // status write
  input wire logic [SMSU_STAT_W-1:0] stat_wdata, // write value
  input wire logic done, // answer
  input wire logic [SMSU_VEC_W-1:0] result, // result
  input wire logic sat, // saturated
  input wire logic [SMSU_STAT_W-1:0] stat // status
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  a_done_after_req: assert property (req |=> done)
    else $error("no answer after request");
  a_done_needs_req: assert property (!req |=> !done)
    else $error("answer without request");
  a_sat_with_done: assert property (sat |-> done)
    else $error("saturation outside an answer");
  a_sat_sets_flag: assert property (sat |-> stat[SMSU_SAT_BIT])
    else $error("saturation left flag clear");
  a_flag_sticky: assert property (stat[SMSU_SAT_BIT] && !stat_wr |=> stat[SMSU_SAT_BIT])
    else $error("flag cleared by an operation");
  a_flag_cause: assert property ($rose(stat[SMSU_SAT_BIT]) |->
    sat || $past(stat_wr && stat_wdata[SMSU_SAT_BIT]))
    else $error("flag set without cause");
  a_write_loads: assert property (stat_wr |=> stat[26:0] == $past(stat_wdata[26:0]))
    else $error("status write not taken");
  a_mull_no_sat: assert property (req && op == SMSU_OP_MULL |=> !sat)
    else $error("plain widening multiply saturated");
  a_min_sq_clamp: assert property (req && op == SMSU_OP_QDMULL && !esz32 && !use_lane &&
    vec_a[15:0] == 16'h8000 && scalar[15:0] == 16'h8000
    |=> result[31:0] == 32'h7fff_ffff && sat)
    else $error("most negative square not clamped");
  a_high_upper_zero: assert property (req && !quad &&
    op inside {SMSU_OP_QDMULH, SMSU_OP_QRDMULH} |=> result[127:64] == '0)
    else $error("narrow high half left upper lanes");
  c_round_sat: cover property (req && op == SMSU_OP_QRDMULH ##1 sat);
  c_lane_req: cover property (req && use_lane && quad);
  c_write: cover property (stat_wr ##1 !stat[SMSU_SAT_BIT]);
endmodule

// *** tb/test_simd_multiply_by_scalar_unit.sv ***
`timescale 1ns/100ps
module test_simd_multiply_by_scalar_unit
  import smsu_pkg::*;
;
  logic i_mclk = 0, i_rst_n = 0, go = 0, e32 = 0, sg = 1, qd = 0, ul = 0, swr = 0;
  smsu_op_t opv = SMSU_OP_MULL;
  logic [1:0] ln = 0;
  logic [127:0] va = 0, res;
  logic [63:0] vb = 0;
  logic [31:0] sc = 0, swd = 0, stv;
  logic busy, rej, val, osat, flag = 0;
  int bad_count = 0, total_checks = 0;
  smsu_if link();
  always #2 i_mclk = ~i_mclk;
  smsu_unit smsu_unit_i(.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(link));
  smsu_issue smsu_issue_i(.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_go(go), .i_op(opv),
    .i_esz32(e32), .i_signed(sg), .i_quad(qd), .i_use_lane(ul), .i_lane(ln), .i_vec_a(va),
    .i_vec_b(vb), .i_scalar(sc), .i_stat_wr(swr), .i_stat_wdata(swd), .o_busy(busy),
    .o_rejected(rej), .o_valid(val), .o_result(res), .o_saturated(osat), .o_status(stv),
    .bus(link));
  smsu_properties smsu_properties_i(.i_mclk(i_mclk), .i_rst_n(i_rst_n), .req(link.req),
    .op(link.op), .esz32(link.esz32), .quad(link.quad), .use_lane(link.use_lane),
    .vec_a(link.vec_a), .scalar(link.scalar), .stat_wr(link.stat_wr),
    .stat_wdata(link.stat_wdata), .done(link.done), .result(link.result), .sat(link.sat),
    .stat(link.stat));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge i_mclk);
    #1;
  endtask
  // 68 bits hold a doubled 32x32 product plus rounding without wrapping
  function automatic logic signed [67:0] ext(input logic [127:0] v, input int w, input bit s);
    logic signed [67:0] r;
    r = v & ((68'd1 << w) - 1);
    if (s && r[w-1]) r = r - (68'sd1 <<< w);
    return r;
  endfunction
  task automatic run();
    int w, ow, n, k;
    bit hi, s, ill, sv;
    logic signed [67:0] a, m, p, lim;
    logic [127:0] er;
    w = e32 ? 32 : 16;
    hi = opv inside {SMSU_OP_QDMULH, SMSU_OP_QRDMULH};
    s = sg || opv != SMSU_OP_MULL;
    ow = hi ? w : 2 * w;
    n = (hi && qd ? 128 : 64) / w;
    ill = (ul && ln > (e32 ? 1 : 3)) || (!sg && opv != SMSU_OP_MULL) || (qd && !hi);
    m = ext(ul ? vb >> (ln * w) : 64'(sc), w, s);
    er = '0;
    sv = 0;
    for (k = 0; k < n; k++) begin
      a = ext(va >> (k * w), w, s);
      p = a * m * (opv == SMSU_OP_MULL ? 1 : 2);
      if (opv == SMSU_OP_QRDMULH) p = p + (68'sd1 <<< (w - 1));
      if (hi) p = p >>> w;
      lim = (68'sd1 <<< (ow - 1)) - 1;
      if (opv != SMSU_OP_MULL && p > lim) begin
        p = lim;
        sv = 1;
      end
      er = er | ((128'(p) & ((128'd1 << ow) - 1)) << (k * ow));
    end
    go = 1;
    tick();
    go = 0;
    chk(128'(busy), 128'(!ill));
    for (k = 0; k < 8 && rej !== 1'b1 && val !== 1'b1; k++) tick();
    if (k == 8) begin
      bad_count++;
      finish_test();
    end
    chk(128'(rej), 128'(ill));
    if (!ill) begin
      flag = flag | sv;
      chk(res, er);
      chk(128'({osat, stv[SMSU_SAT_BIT]}), 128'({sv, flag}));
    end
    tick();
  endtask
  task automatic wstat(input logic [31:0] v);
    swr = 1;
    swd = v;
    tick();
    swr = 0;
    tick();
    flag = v[SMSU_SAT_BIT];
    chk(128'(stv), 128'(v));
  endtask

  initial begin
    int i;
    sc = $urandom(93320);
    repeat (16) @(posedge i_mclk);
    #1;
    i_rst_n = 1;
    tick();
    wstat(32'h0800_0001);
    opv = SMSU_OP_QDMULL;
    va = {8{16'h8000}};
    sc = 32'h0000_8000;
    run();
    for (i = 0; i < 80; i++) begin
      opv = smsu_op_t'($urandom % 4);
      e32 = 1'($urandom);
      sg = $urandom % 4 != 0;
      qd = 1'($urandom);
      ul = 1'($urandom);
      ln = 2'($urandom);
      va = {$urandom, $urandom, $urandom, $urandom};
      vb = va[127:64];
      sc = $urandom;
      // most negative operands are the only way to overflow a doubling
      if ($urandom % 4 == 0) begin
        va = e32 ? {4{32'h8000_0000}} : {8{16'h8000}};
        vb = va[63:0];
        sc = va[31:0];
      end
      if (i % 20 == 10) wstat(32'h0000_0000);
      run();
    end
    finish_test();
  end
endmodule
